// ### core/seac_dwell_timer.sv
// Half-period dwell timer for the relock wait
`timescale 1ns/1ps
module seac_dwell_timer
   import seac_pkg::*;
#(
   parameter int HALF0 = SEAC_HALF_CYC0
)(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       start,
   input  wire logic [2:0] code,
   output logic            halfDone
);
   import seac_pkg::*;

   logic [31:0] count_r;       // Remaining cycles in the half period
   logic        run_r;         // Timer is running
   logic [31:0] loadVal;       // Half period for the chosen code

   // Each code doubles the wait; the short rounding slip is harmless
   assign loadVal = 32'(HALF0) << code;

   // Countdown, one pulse when the half period ends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_r  <= 32'h0;
         run_r    <= 1'b0;
         halfDone <= 1'b0;
      end else begin
         halfDone <= 1'b0;
         if (start) begin
            count_r <= loadVal;
            run_r   <= 1'b1;
         end else if (run_r) begin
            if (count_r <= 32'h1) begin
               run_r    <= 1'b0;
               halfDone <= 1'b1;
            end else begin
               count_r <= count_r - 32'h1;
            end
         end
      end
   end
endmodule

// ### core/seac_pkg.sv
// Package with register map, field layout and timing for the sweep control
package seac_pkg;

   // Register offsets (byte addresses on the register port)
   localparam logic [7:0] SEAC_STROBE_WINDOW_CONFIG = 8'h41;
   localparam logic [7:0] SEAC_ADAPTION_CONTROL_ONE = 8'h42;

   // Reset values
   localparam logic [7:0] SEAC_STROBE_WINDOW_RST   = 8'hA7;
   localparam logic [7:0] SEAC_CONTROL_ONE_RST     = 8'h71;
   localparam logic [2:0] SEAC_RELOCK_RST          = 3'h4;

   // Field positions in the control register
   localparam int SEAC_ERRSEL_HI     = 6;
   localparam int SEAC_ERRSEL_LO     = 4;
   localparam int SEAC_TWO_PHASE_BIT = 2;
   localparam int SEAC_NEST_BIT      = 1;
   localparam int SEAC_SWEEP_BIT     = 0;

   // Control register bits that software may write; bit 7 is read only
   localparam logic [7:0] SEAC_CONTROL_ONE_WMASK = 8'h7F;

   // Strobe range and equalizer range
   localparam logic [3:0] SEAC_STROBE_MAX_POS = 4'hE;
   localparam logic [3:0] SEAC_STROBE_CENTRE  = 4'h7;
   localparam logic [3:0] SEAC_EQ_MAX_LEVEL   = 4'hF;

   // Clock and relock wait times in ns, per code 0..7
   localparam int SEAC_CLK_PERIOD_NS = 4;
   localparam int SEAC_WAIT_NS [8] = '{164000, 328000, 655000, 1310000,
                                        2620000, 5240000, 10500000,
                                        21000000};
   // Half wait count from the shortest time; longer codes shift it up
   localparam int SEAC_HALF_CYC0 = SEAC_WAIT_NS[0] / SEAC_CLK_PERIOD_NS / 2;

   // Sweep controller states, one-hot
   typedef enum logic [3:0] {
      SEAC_IDLE   = 4'b0001,
      SEAC_SETTLE = 4'b0010,
      SEAC_CHECK  = 4'b0100,
      SEAC_HOLD   = 4'b1000
   } seac_state_e;

   // Error inputs travel together
   typedef struct packed {
      logic clockErr;
      logic encodeErr;
      logic parityErr;
   } seac_err_s;

   // Setting applied to the analog front end
   typedef struct packed {
      logic [3:0] eqLevel;
      logic [3:0] strobePos;
   } seac_setting_s;

endpackage

// ### core/seac_sweep_ctrl.sv
// Adaptive equalizer and strobe sweep controller with its two registers
//
// Notes on behaviour
// - Upper strobe limit in high nibble, 0-14
// - Lower strobe limit in low nibble, 0-14
// - Same limits for sweep and dynamic strobe
// - Error-check select bits 6:4, default 0x7
// - Errors counted over half relock wait
// - Count above threshold advances equalizer
// - One phase: full wait, then lock only
// - Two phase: half wait, errors skip fast
// - Two phase also validates each setting
// - Nesting bit picks inner and outer loop
// - Sweep-enable bit adds strobe positions
// - Relock code decodes 164 us to 21 ms
// - Inner loop fully, then outer; first pass
// - Bypass uses manual equalizer stage values
`timescale 1ns/1ps
module seac_sweep_ctrl
   import seac_pkg::*;
#(
   parameter int HALF0 = SEAC_HALF_CYC0   // Half of shortest wait, cycles
)(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                regWrite,
   input  wire logic [7:0]          regAddr,
   input  wire logic [7:0]          regWData,
   output logic [7:0]               regRData,
   input  wire logic [2:0]          relockWaitTime,
   input  wire logic [7:0]          adaptErrorThreshold,
   input  wire logic                equalizerAdaptBypass,
   input  wire logic [3:0]          manualEqLevel,
   input  wire logic                adaptRestart,
   input  wire logic                rxLocked,
   input  wire seac_pkg::seac_err_s errIn,
   output seac_pkg::seac_setting_s  setting,
   output logic [3:0]               strobeLowerLimit,
   output logic [3:0]               strobeUpperLimit,
   output logic                     adaptDone
);
   import seac_pkg::*;

   logic [7:0]    window_r;     // Strobe window register
   logic [7:0]    ctl_r;        // Control register one
   seac_state_e   state_r;      // Sweep state
   logic          phase2_r;     // In the second half of the dwell
   logic [7:0]    errCnt_r;     // Enabled errors in the check phase
   logic          errSeen_r;    // Any enabled error in the check phase
   logic [3:0]    eq_r;         // Current equalizer level
   logic [3:0]    strobe_r;     // Current strobe position
   logic          bypassQ_r;    // Bypass seen last cycle
   logic          timerStart;   // Start a half-period dwell
   logic          halfDone;     // Half period elapsed

   // Decoded fields and selection
   wire logic [3:0] upLim     = window_r[7:4];
   wire logic [3:0] loLim     = window_r[3:0];
   wire logic [2:0] errSel    = ctl_r[SEAC_ERRSEL_HI:SEAC_ERRSEL_LO];
   wire logic       twoPhase  = ctl_r[SEAC_TWO_PHASE_BIT];
   wire logic       eqOuter   = ctl_r[SEAC_NEST_BIT];
   wire logic       sweepEn   = ctl_r[SEAC_SWEEP_BIT];
   wire logic       winSel    = (regAddr == SEAC_STROBE_WINDOW_CONFIG);
   wire logic       ctlSel    = (regAddr == SEAC_ADAPTION_CONTROL_ONE);
   wire logic       errNow    = |({errIn.clockErr, errIn.encodeErr,
                                   errIn.parityErr} & errSel);
   wire logic       overThr   = errCnt_r > adaptErrorThreshold;
   wire logic       eqAtTop   = (eq_r == SEAC_EQ_MAX_LEVEL);
   wire logic       stbAtTop  = !sweepEn || (strobe_r >= upLim);
   wire logic       startSw   = adaptRestart ||
                                (bypassQ_r && !equalizerAdaptBypass);
   // Judged pass: one phase looks at lock only, two phase also errors
   wire logic       passNow   = rxLocked &&
                                !(twoPhase && (errSeen_r || errNow));
   wire logic       failFast  = twoPhase && phase2_r && errNow;

   // Clamp written strobe limits to the legal range of 0-14
   function automatic logic [3:0] clampPos(input logic [3:0] v);
      clampPos = (v > SEAC_STROBE_MAX_POS) ? SEAC_STROBE_MAX_POS : v;
   endfunction

   // Register writes; window limits are clamped so no 15 is ever used
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         window_r <= SEAC_STROBE_WINDOW_RST;
         ctl_r    <= SEAC_CONTROL_ONE_RST;
      end else if (regWrite && winSel) begin
         window_r <= {clampPos(regWData[7:4]),
                      clampPos(regWData[3:0])};
      end else if (regWrite && ctlSel) begin
         ctl_r <= regWData & SEAC_CONTROL_ONE_WMASK;
      end
   end

   // Read mux shows the registers; unmapped reads return zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRData <= 8'h00;
      end else if (winSel) begin
         regRData <= window_r;
      end else if (ctlSel) begin
         regRData <= ctl_r;
      end else begin
         regRData <= 8'h00;
      end
   end

   // Dwell timer: half period per step, two halves per setting
   seac_dwell_timer #(
      .HALF0 (HALF0)
   ) u_timer (
      .clk      (clk),
      .rst_b    (rst_b),
      .start    (timerStart),
      .code     (relockWaitTime),
      .halfDone (halfDone)
   );

   // Timer starts on entry to settle and at the start of the check half;
   // a restart from hold must reload it too, or settle would never end
   assign timerStart = (state_r == SEAC_IDLE && startSw) ||
                       (state_r == SEAC_HOLD &&
                        (adaptRestart || !rxLocked) &&
                        !equalizerAdaptBypass) ||
                       (state_r == SEAC_SETTLE && halfDone) ||
                       (state_r == SEAC_CHECK && (failFast ||
                        (halfDone && phase2_r && !passNow)));

   // Sweep state machine
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r   <= SEAC_IDLE;
         phase2_r  <= 1'b0;
         errCnt_r  <= 8'h00;
         errSeen_r <= 1'b0;
         eq_r      <= 4'h0;
         strobe_r  <= SEAC_STROBE_CENTRE;
         bypassQ_r <= 1'b1;
         adaptDone <= 1'b0;
      end else begin
         bypassQ_r <= equalizerAdaptBypass;
         if (equalizerAdaptBypass) begin
            // Manual stage values drive the front end
            state_r   <= SEAC_IDLE;
            adaptDone <= 1'b0;
            eq_r      <= manualEqLevel;
         end else begin
            case (state_r)
               SEAC_IDLE: begin
                  if (startSw) begin
                     state_r   <= SEAC_SETTLE;
                     eq_r      <= 4'h0;
                     // Sweep off starts from idle at the centre, never at a stale
                     // position left over from an earlier sweep
                     strobe_r  <= sweepEn ? loLim
                                          : SEAC_STROBE_CENTRE;
                     adaptDone <= 1'b0;
                  end
               end
               SEAC_SETTLE: begin
                  // First half of the dwell, errors not judged
                  if (halfDone) begin
                     state_r   <= SEAC_CHECK;
                     phase2_r  <= 1'b0;
                     errCnt_r  <= 8'h00;
                     errSeen_r <= 1'b0;
                  end
               end
               SEAC_CHECK: begin
                  // Second half: count enabled errors
                  if (errNow && errCnt_r != 8'hFF) begin
                     errCnt_r <= errCnt_r + 8'h01;
                  end
                  errSeen_r <= errSeen_r | errNow;
                  if (!phase2_r) begin
                     // One arm cycle; the check half is already timing,
                     // so settle plus check add up to one relock wait
                     phase2_r <= 1'b1;
                  end else if (failFast ||
                               (halfDone && phase2_r && !passNow)) begin
                     // Step to next setting, inner loop first
                     state_r   <= SEAC_SETTLE;
                     errCnt_r  <= 8'h00;
                     errSeen_r <= 1'b0;
                     if (overThr && !eqAtTop) begin
                        eq_r <= eq_r + 4'h1;
                     end else if (!eqOuter || !sweepEn) begin
                        // Equalizer inner loop
                        if (!eqAtTop) begin
                           eq_r <= eq_r + 4'h1;
                        end else begin
                           eq_r <= 4'h0;
                           // Strobe stays put while its sweep is off
                           if (sweepEn) begin
                              strobe_r <= stbAtTop ? loLim
                                                   : strobe_r + 4'h1;
                           end
                        end
                     end else begin
                        // Strobe inner loop
                        if (!stbAtTop) begin
                           strobe_r <= strobe_r + 4'h1;
                        end else begin
                           strobe_r <= loLim;
                           eq_r     <= eq_r + 4'h1;
                        end
                     end
                  end else if (halfDone && phase2_r) begin
                     // Pass: one phase uses lock only
                     state_r   <= SEAC_HOLD;
                     adaptDone <= 1'b1;
                  end
               end
               SEAC_HOLD: begin
                  // Keep setting until restart or unlock
                  if (adaptRestart || !rxLocked) begin
                     state_r   <= SEAC_SETTLE;
                     eq_r      <= 4'h0;
                     strobe_r  <= sweepEn ? loLim : strobe_r;
                     adaptDone <= 1'b0;
                  end
               end
               default: state_r <= SEAC_IDLE;
            endcase
         end
      end
   end

   // Outputs from flip-flops only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         setting          <= '0;
         strobeLowerLimit <= 4'h0;
         strobeUpperLimit <= 4'h0;
      end else begin
         setting          <= '{eqLevel: eq_r, strobePos: strobe_r};
         strobeLowerLimit <= loLim;
         strobeUpperLimit <= upLim;
      end
   end

   // Assertions
   // Stored limits never reach position 15
   chk_limits_legal: assert property (
      @(posedge clk) disable iff (!rst_b)
      upLim <= SEAC_STROBE_MAX_POS && loLim <= SEAC_STROBE_MAX_POS)
      else $error("strobe limit above 14");
   // A legal lower limit lands unchanged
   chk_window_write: assert property (
      @(posedge clk) disable iff (!rst_b)
      regWrite && winSel && regWData[3:0] <= 4'hE
      |=> loLim == $past(regWData[3:0]))
      else $error("lower limit not stored");
   // Error select lands, reserved top bit stays clear
   chk_ctl_write: assert property (
      @(posedge clk) disable iff (!rst_b)
      regWrite && ctlSel
      |=> errSel == $past(regWData[6:4]) && !ctl_r[7])
      else $error("control write lost");
   // In two phase, an error in the counted half moves on at once
   chk_fast_skip: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_r == SEAC_CHECK && failFast && !equalizerAdaptBypass
      |=> state_r == SEAC_SETTLE)
      else $error("two phase error did not skip");
   // A held setting does not drift while lock stays
   chk_hold_stable: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_r == SEAC_HOLD && rxLocked && !adaptRestart &&
      !equalizerAdaptBypass |=> $stable(eq_r) && $stable(strobe_r))
      else $error("held setting moved");
   // A pass is only taken with lock present
   chk_hold_lock: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_r == SEAC_CHECK && $past(state_r) == SEAC_CHECK ##1
      state_r == SEAC_HOLD |-> $past(rxLocked))
      else $error("pass without lock");
   // Bypass parks the sweep and follows the manual level
   chk_bypass_idle: assert property (
      @(posedge clk) disable iff (!rst_b)
      equalizerAdaptBypass
      |=> state_r == SEAC_IDLE && eq_r == $past(manualEqLevel))
      else $error("bypass did not stop adaption");
   // Each new setting keeps the strobe at or below the upper limit
   chk_strobe_window: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_r == SEAC_CHECK && sweepEn && upLim >= loLim &&
      $stable(window_r) && $past(state_r) == SEAC_SETTLE
      |-> strobe_r <= upLim)
      else $error("strobe outside window");
   // With its sweep off the strobe moves only on a start from idle, to the centre
   chk_no_strobe: assert property (
      @(posedge clk) disable iff (!rst_b)
      !sweepEn && state_r != SEAC_IDLE && !equalizerAdaptBypass &&
      !startSw |=> $stable(strobe_r))
      else $error("strobe moved while sweep off");
   // Too many errors push the equalizer up one level
   chk_thresh_step: assert property (
      @(posedge clk) disable iff (!rst_b)
      state_r == SEAC_CHECK && phase2_r && halfDone && !passNow &&
      overThr && !eqAtTop && !equalizerAdaptBypass
      |=> eq_r == $past(eq_r) + 4'h1)
      else $error("no equalizer step over threshold");

   // Main scenarios: pass, fast skip, strobe inner loop, restart, step
   cov_pass: cover property (@(posedge clk) state_r == SEAC_HOLD);
   cov_fast: cover property (@(posedge clk) failFast);
   cov_outer: cover property (@(posedge clk)
      eqOuter && state_r == SEAC_CHECK && halfDone && phase2_r);
   cov_restart: cover property (@(posedge clk)
      state_r == SEAC_HOLD && adaptRestart);
   cov_thresh: cover property (@(posedge clk)
      state_r == SEAC_CHECK && halfDone && overThr && !eqAtTop);
endmodule

// ### sim/seac_link_model.sv
// Far-end link model: lock and error pattern seen for each setting
`timescale 1ns/1ps
module seac_link_model
   import seac_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire seac_pkg::seac_setting_s setting,
   input  wire logic [7:0]              lockA,
   input  wire logic [7:0]              lockB,
   input  wire logic                    allLock,
   input  wire logic                    dropLock,
   input  wire logic [3:0]              errBelow,
   input  wire logic [2:0]              errKinds,
   output seac_pkg::seac_err_s          errIn,
   output logic                         rxLocked
);
   import seac_pkg::*;

   // Lock only at chosen settings unless allLock is set, so the sweep path shows in the result
   logic lockHit;
   assign lockHit = allLock | (setting == lockA) | (setting == lockB);

   // One cycle behind the setting, as a real receiver would be
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rxLocked <= 1'b0;
         errIn    <= '0;
      end else begin
         rxLocked <= lockHit & ~dropLock;
         // Errors every cycle while the equalizer is too weak
         errIn    <= (setting.eqLevel < errBelow) ? errKinds : 3'h0;
      end
   end
endmodule

// ### sim/tb.sv
// Self-checking bench for the equalizer and strobe sweep controller
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
   import seac_pkg::*;
   localparam int H = 8;           // Short half wait keeps the run brief
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          regWrite = 1'b0;
   logic [7:0]    regAddr = 8'h00;
   logic [7:0]    regWData = 8'h00;
   logic [7:0]    regRData;
   logic [2:0]    relockWaitTime = 3'h0;
   logic [7:0]    adaptErrorThreshold = 8'hFF;
   logic          bypass = 1'b1;    // Held high so nothing sweeps early
   logic [3:0]    manualEqLevel = 4'h0;
   logic          adaptRestart = 1'b0;
   logic          rxLocked;
   seac_err_s     errIn;
   seac_setting_s setting;
   logic [3:0]    lowLim;
   logic [3:0]    upLim;
   logic          adaptDone;
   logic [7:0]    lockA = 8'h57;
   logic [7:0]    lockB = 8'h28;
   logic          allLock = 1'b0;
   logic          dropLock = 1'b0;
   logic [3:0]    errBelow = 4'h0;
   logic [2:0]    errKinds = 3'h0;
   int            n_fail = 0;
   int            compares = 0;
   int            lat;
   logic [7:0]    d;

   always #2 clk = ~clk;

   seac_sweep_ctrl #(.HALF0(H)) u_dut (.clk(clk), .rst_b(rst_b),
      .regWrite(regWrite), .regAddr(regAddr), .regWData(regWData),
      .regRData(regRData), .relockWaitTime(relockWaitTime),
      .adaptErrorThreshold(adaptErrorThreshold),
      .equalizerAdaptBypass(bypass), .manualEqLevel(manualEqLevel),
      .adaptRestart(adaptRestart), .rxLocked(rxLocked), .errIn(errIn),
      .setting(setting), .strobeLowerLimit(lowLim),
      .strobeUpperLimit(upLim), .adaptDone(adaptDone));

   seac_link_model u_link (.clk(clk), .rst_b(rst_b), .setting(setting),
      .lockA(lockA), .lockB(lockB), .allLock(allLock),
      .dropLock(dropLock), .errBelow(errBelow), .errKinds(errKinds),
      .errIn(errIn), .rxLocked(rxLocked));

   // Prints the counts and the verdict, then stops
   task automatic complete_run;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One-cycle write pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWData = v;
      @(negedge clk);
      regWrite = 1'b0;
   endtask

   // Read data is registered, so wait past two edges
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      regAddr = a;
      repeat (2) @(negedge clk);
      v = regRData;
   endtask

   // Idle via bypass, program, start on bypass fall, wait for a pass
   task automatic run_sweep(input logic [7:0] win, input logic [7:0] ctl,
                            input logic [2:0] code, output int n);
      logic outR;
      outR = 1'b0;
      @(negedge clk);
      bypass = 1'b1;
      repeat (3) @(negedge clk);
      wr(SEAC_STROBE_WINDOW_CONFIG, win);
      wr(SEAC_ADAPTION_CONTROL_ONE, ctl);
      relockWaitTime = code;
      @(negedge clk);
      bypass = 1'b0;
      n = 0;
      while (adaptDone !== 1'b1 && n < 6000) begin
         @(negedge clk);
         n++;
         if (n > 2 && (setting.strobePos < win[3:0] ||
                       setting.strobePos > win[7:4])) begin
            outR = 1'b1;
         end
      end
      @(negedge clk);
      `CHK(outR, 1'b0)
      `CHK(adaptDone, 1'b1)
   endtask

   // Sweep with a narrow window and compare the setting that was kept
   task automatic sweep_exp(input logic [7:0] ctl, input logic [7:0] e);
      int n;
      run_sweep(8'h87, ctl, 3'h0, n);
      `CHK(setting, e)
   endtask

   // Reset values, clamping, read-only bit and an unmapped address
   task automatic test_regs;
      rd(SEAC_STROBE_WINDOW_CONFIG, d);
      `CHK(d, SEAC_STROBE_WINDOW_RST)
      rd(SEAC_ADAPTION_CONTROL_ONE, d);
      `CHK(d, 8'h71)
      wr(SEAC_STROBE_WINDOW_CONFIG, 8'hA9);
      rd(SEAC_STROBE_WINDOW_CONFIG, d);
      `CHK(d, 8'hA9)
      `CHK({upLim, lowLim}, 8'hA9)
      wr(SEAC_STROBE_WINDOW_CONFIG, 8'hFF);
      rd(SEAC_STROBE_WINDOW_CONFIG, d);
      `CHK(d, 8'hEE)
      wr(SEAC_ADAPTION_CONTROL_ONE, 8'hFF);
      rd(SEAC_ADAPTION_CONTROL_ONE, d);
      `CHK(d, 8'h7F)
      rd(8'h43, d);
      `CHK(d, 8'h00)
   endtask

   // Bypass drives the manual level and never reports a pass
   task automatic test_bypass;
      manualEqLevel = 4'h9;
      repeat (4) @(negedge clk);
      `CHK(setting.eqLevel, 4'h9)
      `CHK(adaptDone, 1'b0)
   endtask

   // Held setting survives idle time, then drops on restart and unlock
   task automatic test_hold;
      repeat (40) @(negedge clk);
      `CHK({adaptDone, setting}, 9'h157)
      adaptRestart = 1'b1;
      @(negedge clk);
      adaptRestart = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(adaptDone, 1'b0)
      lat = 0;
      while (adaptDone !== 1'b1 && lat < 3000) begin
         @(negedge clk);
         lat++;
      end
      `CHK({adaptDone, setting}, 9'h157)
      dropLock = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(adaptDone, 1'b0)
      dropLock = 1'b0;
   endtask

   initial begin
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      test_regs();
      test_bypass();
      sweep_exp(8'h71, 8'h57);
      sweep_exp(8'h73, 8'h28);
      sweep_exp(8'h72, 8'h57);
      test_hold();
      // Lock everywhere, errors below level 4: only checked kinds count
      allLock = 1'b1;
      errBelow = 4'h4;
      for (int k = 0; k < 3; k++) begin
         errKinds = 3'b100 >> k;
         sweep_exp({1'b0, 3'b100 >> k, 4'h5}, 8'h47);
      end
      sweep_exp(8'h45, 8'h07);
      errKinds = 3'h7;
      sweep_exp(8'h05, 8'h07);
      sweep_exp(8'h71, 8'h07);
      // Threshold jumps the equalizer past the early locking point
      allLock = 1'b0;
      lockA = 8'h48;
      lockB = 8'h18;
      errKinds = 3'h1;
      adaptErrorThreshold = 8'h02;
      sweep_exp(8'h13, 8'h48);
      adaptErrorThreshold = 8'hFF;
      sweep_exp(8'h13, 8'h18);
      // Dwell grows with the relock code; window 7 to 10
      allLock = 1'b1;
      errBelow = 4'h0;
      for (int c = 0; c < 8; c++) begin
         run_sweep(8'hA7, 8'h71, c[2:0], lat);
         `CHK(lat >= 2*(H<<c) && lat <= 2*(H<<c) + 10, 1'b1)
      end
      // Window 6 to 7 around the centre, strobe loop inside
      run_sweep(8'h76, 8'h73, 3'h0, lat);
      `CHK(setting, 8'h06)
      complete_run();
   end

   // Hang guard, far beyond the expected few thousand cycles
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      complete_run();
   end
endmodule
